// File: stmctl_timer.sv
// standard 16-bit timer with register port, compare, capture and pwm output
`timescale 1ns/1ps
`include "stmctl_regs.svh"

// Operation
// - pause bit high holds the count; low resumes from held value.
// - three-bit select picks sys/4, sys, high/16, high/64, sub or ext edges.
// - timer-on rising clears counter; falling stops and keeps the count.
// - counter runs only while timer-on is set; otherwise switched off.
// - timer-on rising edge returns the pin to its initial level in compare mode and in pwm waveform or single pulse.
// - control register 0 bits 2 to 0 read as zero.
// - two-bit mode: compare, capture, pwm or single pulse, timer/counter.
// - compare mode pin reaction: none, low, high, toggle on match A.
// - pwm mode pin: inactive, active, pwm waveform, single pulse.
// - capture mode edge: rising, falling, both, disabled.
// - match level equal to initial level gives no visible change.
// - initial level bit sets start level or active level.
// - polarity bit inverts the output pin in every mode, timer/counter included.
// - swap bit exchanges period and duty roles of compare P and A.
// - clear on match A when set; else match P or overflow.
// - clear select ignored in pwm, single pulse and capture modes.
// - counter readable as read-only low and high bytes, reset zero.
// - compare A held in read/write low and high bytes, reset zero.
// - compare P matches counter bits 15 to 8; zero means 65536.
// - low bytes pass an 8-bit buffer moved on high-byte access.
// - counter core is a 16-bit up counter on the selected clock.
// - separate flags raised on match A when A is nonzero and on match P unless compare or timer mode clears on match A.
module stmctl_timer
    import stmctl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // register port
    input  wire logic [2:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // clock enables of the other internal clocks, same clock domain
    input  wire logic             high_clk_tick,
    input  wire logic             sub_clk_tick,
    // pins
    input  wire logic             external_clock_pin,
    input  wire logic             capture_input_pin,
    output logic                  timer_output_pin,
    output logic                  timer_output_pin_oe,
    // events
    output logic                  compare_a_flag,
    output logic                  compare_p_flag
);

    // ==================================================================
    // registers
    logic                  pause_control_r;
    stmctl_cksel_type      counter_clock_select_r;
    logic                  timer_on_r;
    stmctl_mode_type       operating_mode_select_r;
    logic [1:0]            pin_function_select_r;
    logic                  output_initial_level_r;
    logic                  output_polarity_r;
    logic                  duty_period_swap_r;
    logic                  clear_source_select_r;
    logic [CNT_W-1:0]      compare_a_value_r;
    logic [7:0]            compare_p_value_r;
    logic [7:0]            low_buf_r;
    logic [CNT_W-1:0]      count_r;
    logic [CNT_W-1:0]      count_nxt;
    logic [CNT_W-1:0]      capture_r;
    logic                  on_d_r;
    logic                  pin_r;
    logic                  pin_nxt;
    logic                  aflag_r;
    logic                  pflag_r;
    logic                  capt_flag_r;
    stmctl_sp_type         sp_state_r;
    logic [7:0]            presc_r;
    logic                  ext_s1_r;
    logic                  ext_s2_r;
    logic                  ext_s3_r;
    logic                  cap_s1_r;
    logic                  cap_s2_r;
    logic                  cap_s3_r;

    wire logic             wr_c0   = reg_wr && reg_addr == `STMCTL_OFF_CTRL0;
    wire logic             wr_c1   = reg_wr && reg_addr == `STMCTL_OFF_CTRL1;
    wire logic             on_rise = timer_on_r && !on_d_r;

    // ==================================================================
    // control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pause_control_r         <= 1'b0;
            counter_clock_select_r  <= STMCTL_CK_SYS4;
            timer_on_r              <= 1'b0;
        end else if (wr_c0) begin
            pause_control_r         <= reg_wdata[`STMCTL_C0_PAUSE];
            counter_clock_select_r  <= stmctl_cksel_type'(
                reg_wdata[`STMCTL_C0_CKSEL_HI:`STMCTL_C0_CKSEL_LO]);
            timer_on_r              <= reg_wdata[`STMCTL_C0_ON];
        end else if (sp_state_r == STMCTL_SP_DONE) begin
            timer_on_r              <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            operating_mode_select_r <= STMCTL_MODE_CMP;
            pin_function_select_r   <= 2'h0;
            output_initial_level_r  <= 1'b0;
            output_polarity_r       <= 1'b0;
            duty_period_swap_r      <= 1'b0;
            clear_source_select_r   <= 1'b0;
        end else if (wr_c1) begin
            operating_mode_select_r <= stmctl_mode_type'(
                reg_wdata[`STMCTL_C1_MODE_HI:`STMCTL_C1_MODE_LO]);
            pin_function_select_r   <= reg_wdata[`STMCTL_C1_PINF_HI:`STMCTL_C1_PINF_LO];
            output_initial_level_r  <= reg_wdata[`STMCTL_C1_INIT];
            output_polarity_r       <= reg_wdata[`STMCTL_C1_POL];
            duty_period_swap_r      <= reg_wdata[`STMCTL_C1_DPX];
            clear_source_select_r   <= reg_wdata[`STMCTL_C1_CCLR];
        end
    end

    // compare values: compare A through the shared low-byte buffer, compare P written directly
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_buf_r         <= `STMCTL_RST_BYTE;
            compare_a_value_r <= `STMCTL_RST_WORD;
            compare_p_value_r <= `STMCTL_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `STMCTL_OFF_CMPA_LO: low_buf_r <= reg_wdata;
                `STMCTL_OFF_CMPA_HI: compare_a_value_r <= {reg_wdata, low_buf_r};
                `STMCTL_OFF_CMPP:    compare_p_value_r <= reg_wdata;
                default: ;
            endcase
        end else if (reg_rd) begin
            case (reg_addr)
                `STMCTL_OFF_CNT_HI:  low_buf_r <= count_r[7:0];
                `STMCTL_OFF_CMPA_HI: low_buf_r <= compare_a_value_r[7:0];
                default: ;
            endcase
        end
    end

    // ==================================================================
    // synchronisers for pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            cap_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= external_clock_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            cap_s1_r <= capture_input_pin;
            cap_s2_r <= cap_s1_r;
            cap_s3_r <= cap_s2_r;
        end
    end

    // ==================================================================
    // counter clock selection
    logic tick;
    always_comb begin
        case (counter_clock_select_r)
            STMCTL_CK_SYS4:     tick = presc_r[1:0] == 2'(`STMCTL_DIV_SYS4);
            STMCTL_CK_SYS:      tick = 1'b1;
            STMCTL_CK_H16:      tick = high_clk_tick && presc_r[3:0] == 4'(`STMCTL_DIV_H16);
            STMCTL_CK_H64:      tick = high_clk_tick && presc_r[5:0] == 6'(`STMCTL_DIV_H64);
            STMCTL_CK_SUB0,
            STMCTL_CK_SUB1:     tick = sub_clk_tick;
            STMCTL_CK_EXT_RISE: tick = ext_s2_r && !ext_s3_r;
            STMCTL_CK_EXT_FALL: tick = !ext_s2_r && ext_s3_r;
            default:            tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_r <= 8'h00;
        end else if (!timer_on_r) begin
            presc_r <= 8'h00;
        end else if (counter_clock_select_r == STMCTL_CK_SYS4 ||
                     (high_clk_tick && !pause_control_r)) begin
            presc_r <= presc_r + 8'h01;
        end
    end

    // ==================================================================
    // comparators and clear source
    wire logic run     = timer_on_r && !pause_control_r && tick;
    wire logic match_a = run && count_r == compare_a_value_r;
    wire logic match_p = run && compare_p_value_r != 8'h00 &&
                         count_r[CNT_W-1:CNT_W-8] == compare_p_value_r &&
                         count_r[CNT_W-9:0] == '0;
    wire logic ovf     = run && count_r == '1;
    wire logic is_pwm  = operating_mode_select_r == STMCTL_MODE_PWM;
    wire logic a_nz    = compare_a_value_r != '0;
    logic      clr;

    always_comb begin
        case (operating_mode_select_r)
            STMCTL_MODE_CMP,
            STMCTL_MODE_TMR:
                clr = clear_source_select_r ? match_a && a_nz
                                            : match_p || ovf;
            STMCTL_MODE_PWM:
                clr = duty_period_swap_r ? match_a : match_p || ovf;
            default:
                clr = ovf;
        endcase
    end

    always_comb begin
        count_nxt = count_r;
        if (on_rise)
            count_nxt = '0;
        else if (clr)
            count_nxt = '0;
        else if (run)
            count_nxt = count_r + 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= `STMCTL_RST_WORD;
            on_d_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            on_d_r  <= timer_on_r;
        end
    end

    // ==================================================================
    // event flags, set wins over software clear
    wire logic evt_a = match_a && a_nz;
    wire logic evt_p = match_p && !(clear_source_select_r &&
                       (operating_mode_select_r == STMCTL_MODE_CMP ||
                        operating_mode_select_r == STMCTL_MODE_TMR));
    wire logic wr_st = reg_wr && reg_addr == `STMCTL_OFF_STATUS;

    // capture
    logic cap_evt;
    always_comb begin
        case (pin_function_select_r)
            2'h0:    cap_evt = cap_s2_r && !cap_s3_r;
            2'h1:    cap_evt = !cap_s2_r && cap_s3_r;
            2'h2:    cap_evt = cap_s2_r != cap_s3_r;
            default: cap_evt = 1'b0;
        endcase
    end
    wire logic capt = cap_evt && timer_on_r &&
                      operating_mode_select_r == STMCTL_MODE_CAPT;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aflag_r     <= 1'b0;
            pflag_r     <= 1'b0;
            capt_flag_r <= 1'b0;
            capture_r   <= `STMCTL_RST_WORD;
        end else begin
            aflag_r     <= evt_a || capt ||
                           (aflag_r && !(wr_st && reg_wdata[`STMCTL_ST_AFLAG]));
            pflag_r     <= evt_p ||
                           (pflag_r && !(wr_st && reg_wdata[`STMCTL_ST_PFLAG]));
            capt_flag_r <= capt ||
                           (capt_flag_r && !(wr_st && reg_wdata[`STMCTL_ST_CAPT]));
            if (capt)
                capture_r <= count_r;
        end
    end

    // ==================================================================
    // output pin logic
    wire logic [CNT_W-1:0] p_full = {compare_p_value_r, 8'h00};
    wire logic             duty_on = duty_period_swap_r
        ? (compare_p_value_r == 8'h00 || count_r < p_full)
        : (count_r < compare_a_value_r);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_state_r <= STMCTL_SP_IDLE;
        end else if (!is_pwm || pin_function_select_r != 2'h3) begin
            sp_state_r <= STMCTL_SP_IDLE;
        end else begin
            case (sp_state_r)
                STMCTL_SP_IDLE:   if (on_rise) sp_state_r <= STMCTL_SP_ACTIVE;
                STMCTL_SP_ACTIVE: if (!timer_on_r) sp_state_r <= STMCTL_SP_IDLE;
                                  else if (match_a) sp_state_r <= STMCTL_SP_DONE;
                STMCTL_SP_DONE:   sp_state_r <= STMCTL_SP_IDLE;
                default:          sp_state_r <= STMCTL_SP_IDLE;
            endcase
        end
    end

    always_comb begin
        pin_nxt = pin_r;
        case (operating_mode_select_r)
            STMCTL_MODE_CMP: begin
                if (on_rise)
                    pin_nxt = output_initial_level_r;
                else if (evt_a) begin
                    case (pin_function_select_r)
                        2'h1:    pin_nxt = 1'b0;
                        2'h2:    pin_nxt = 1'b1;
                        2'h3:    pin_nxt = !pin_r;
                        default: pin_nxt = pin_r;
                    endcase
                end
            end
            STMCTL_MODE_PWM: begin
                case (pin_function_select_r)
                    2'h0:    pin_nxt = !output_initial_level_r;
                    2'h1:    pin_nxt = output_initial_level_r;
                    2'h2:    pin_nxt = on_rise ? output_initial_level_r
                                       : (timer_on_r && duty_on) == output_initial_level_r;
                    default: pin_nxt = (on_rise || sp_state_r == STMCTL_SP_ACTIVE)
                                       ? output_initial_level_r
                                       : !output_initial_level_r;
                endcase
            end
            default: pin_nxt = pin_r;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_r               <= 1'b0;
            timer_output_pin    <= 1'b0;
            timer_output_pin_oe <= 1'b0;
            compare_a_flag      <= 1'b0;
            compare_p_flag      <= 1'b0;
        end else begin
            pin_r               <= pin_nxt;
            timer_output_pin    <= pin_nxt ^ output_polarity_r;
            timer_output_pin_oe <= operating_mode_select_r == STMCTL_MODE_CMP || is_pwm;
            compare_a_flag      <= aflag_r;
            compare_p_flag      <= pflag_r;
        end
    end

    // ==================================================================
    // read port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `STMCTL_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `STMCTL_OFF_CTRL0:   reg_rdata <= {pause_control_r, counter_clock_select_r,
                                                   timer_on_r, 3'h0};
                `STMCTL_OFF_CTRL1:   reg_rdata <= {operating_mode_select_r,
                                                   pin_function_select_r,
                                                   output_initial_level_r, output_polarity_r,
                                                   duty_period_swap_r, clear_source_select_r};
                `STMCTL_OFF_CNT_LO:  reg_rdata <= low_buf_r;
                `STMCTL_OFF_CNT_HI:  reg_rdata <= count_r[15:8];
                `STMCTL_OFF_CMPA_LO: reg_rdata <= low_buf_r;
                `STMCTL_OFF_CMPA_HI: reg_rdata <= compare_a_value_r[15:8];
                `STMCTL_OFF_CMPP:    reg_rdata <= compare_p_value_r;
                `STMCTL_OFF_STATUS:  reg_rdata <= {5'h00, capt_flag_r, pflag_r, aflag_r};
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : stmctl_timer

// File: stmctl_regs.svh
// register offsets, field positions, reset values and timing counts of the standard timer
`ifndef STMCTL_REGS_SVH
`define STMCTL_REGS_SVH

// ======================================================================
// register offsets
`define STMCTL_OFF_CTRL0      3'h0
`define STMCTL_OFF_CTRL1      3'h1
`define STMCTL_OFF_CNT_LO     3'h2
`define STMCTL_OFF_CNT_HI     3'h3
`define STMCTL_OFF_CMPA_LO    3'h4
`define STMCTL_OFF_CMPA_HI    3'h5
`define STMCTL_OFF_CMPP       3'h6
`define STMCTL_OFF_STATUS     3'h7

// ======================================================================
// field positions
`define STMCTL_C0_PAUSE       7
`define STMCTL_C0_CKSEL_HI    6
`define STMCTL_C0_CKSEL_LO    4
`define STMCTL_C0_ON          3
`define STMCTL_C1_MODE_HI     7
`define STMCTL_C1_MODE_LO     6
`define STMCTL_C1_PINF_HI     5
`define STMCTL_C1_PINF_LO     4
`define STMCTL_C1_INIT        3
`define STMCTL_C1_POL         2
`define STMCTL_C1_DPX         1
`define STMCTL_C1_CCLR        0
`define STMCTL_ST_AFLAG       0
`define STMCTL_ST_PFLAG       1
`define STMCTL_ST_CAPT        2

// ======================================================================
// reset values
`define STMCTL_RST_BYTE       8'h00
`define STMCTL_RST_WORD       16'h0000

// ======================================================================
// timing counts: prescaler divisions
`define STMCTL_DIV_SYS4       8'h03
`define STMCTL_DIV_H16        8'h0F
`define STMCTL_DIV_H64        8'h3F

`endif

// File: stmctl_pkg.sv
// types shared by the standard timer block
package stmctl_pkg;

    typedef enum logic [1:0] {
        STMCTL_MODE_CMP,
        STMCTL_MODE_CAPT,
        STMCTL_MODE_PWM,
        STMCTL_MODE_TMR
    } stmctl_mode_type;

    typedef enum logic [2:0] {
        STMCTL_CK_SYS4,
        STMCTL_CK_SYS,
        STMCTL_CK_H16,
        STMCTL_CK_H64,
        STMCTL_CK_SUB0,
        STMCTL_CK_SUB1,
        STMCTL_CK_EXT_RISE,
        STMCTL_CK_EXT_FALL
    } stmctl_cksel_type;

    typedef enum logic [1:0] {
        STMCTL_SP_IDLE,
        STMCTL_SP_ACTIVE,
        STMCTL_SP_DONE
    } stmctl_sp_type;

endpackage : stmctl_pkg

// File: stmctl_timer_props.sv
// checker of the standard timer register port and pin behaviour
`timescale 1ns/1ps
module stmctl_timer_props
    import stmctl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock, reset and register port
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // ticks, pins and events
    input wire logic       high_clk_tick,
    input wire logic       sub_clk_tick,
    input wire logic       external_clock_pin,
    input wire logic       capture_input_pin,
    input wire logic       timer_output_pin,
    input wire logic       timer_output_pin_oe,
    input wire logic       compare_a_flag,
    input wire logic       compare_p_flag
);
    logic [7:0]  c0_r, c1_r, buf_r;
    logic [15:0] a_r;
    // ======================================================================
    // shadow of written control and compare values
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {c0_r, c1_r, buf_r, a_r} <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                3'h0: c0_r <= reg_wdata;
                3'h1: c1_r <= reg_wdata;
                3'h4: buf_r <= reg_wdata;
                3'h5: a_r <= {reg_wdata, buf_r};
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ======================================================================
    // assertions
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside answer");
    chk_ctrl0_read: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0
        |-> reg_rdata[7:4] == c0_r[7:4] && reg_rdata[2:0] == 3'h0)
        else $error("control 0 read wrong");
    chk_ctrl1_read: assert property ($past(reg_rd) && $past(reg_addr) == 3'h1
        |-> reg_rdata == c1_r) else $error("control 1 read wrong");
    chk_cmpa_high: assert property ($past(reg_rd) && $past(reg_addr) == 3'h5
        |-> reg_rdata == a_r[15:8]) else $error("compare a high wrong");
    chk_cmpa_low: assert property (reg_rd && reg_addr == 3'h5 ##2 reg_rd && reg_addr == 3'h4
        |=> reg_rdata == a_r[7:0]) else $error("compare a low wrong");
    chk_oe_counter: assert property ((c1_r[7:6] == 2'b11) [*3] |-> !timer_output_pin_oe)
        else $error("pin driven in counter mode");
    chk_oe_compare: assert property ((c1_r[7:6] == 2'b00) [*3] |-> timer_output_pin_oe)
        else $error("pin not driven in compare mode");
    chk_pin_start: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[3] && !c0_r[3]
        && c1_r[7:6] == 2'b00 |-> ##[1:3] timer_output_pin == (c1_r[3] ^ c1_r[2]))
        else $error("pin not at start level");
    cov_flag_a: cover property ($rose(compare_a_flag));
    cov_oe_off: cover property ($fell(timer_output_pin_oe));
    cov_pin_up: cover property ($rose(timer_output_pin));
endmodule : stmctl_timer_props
bind stmctl_timer stmctl_timer_props #(.CNT_W(CNT_W)) stmctl_timer_props_inst (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .high_clk_tick, .sub_clk_tick, .external_clock_pin, .capture_input_pin,
    .timer_output_pin, .timer_output_pin_oe, .compare_a_flag, .compare_p_flag
);

// File: stmctl_pin_model.sv
// far-side pin drivers: external clock bursts and capture level
`timescale 1ns/1ps
module stmctl_pin_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // bench control
    input  wire logic       go,
    input  wire logic [7:0] n_pulses,
    input  wire logic       cap_level,
    // pins
    output logic            external_clock_pin,
    output logic            capture_input_pin,
    output logic            busy
);
    logic [7:0] left_r;
    logic [2:0] ph_r;
    // pulses four cycles high, four low; pin stands low between bursts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {left_r, ph_r} <= '0;
        end else if (go) begin
            left_r <= n_pulses;
            ph_r   <= 3'h0;
        end else if (left_r != 8'h00) begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == 3'h7) begin
                left_r <= left_r - 8'h01;
            end
        end
    end
    assign external_clock_pin = (left_r != 8'h00) && !ph_r[2];
    assign capture_input_pin  = cap_level;
    assign busy               = left_r != 8'h00;
endmodule : stmctl_pin_model

// File: stmctl_timer_tb_top.sv
// self-checking bench of the standard timer registers and pins
`timescale 1ns/1ps
module stmctl_timer_tb_top;
    logic        clk, reset_n, reg_wr, reg_rd, go, cap_level, busy;
    logic        external_clock_pin, capture_input_pin, timer_output_pin;
    logic        timer_output_pin_oe, compare_a_flag, compare_p_flag;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, n_pulses, v8;
    logic [15:0] v, w;
    int          n_fail, total_checks;

    stmctl_timer stmctl_timer_inst (
        .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .high_clk_tick (1'b1), .sub_clk_tick (1'b0), .external_clock_pin,
        .capture_input_pin, .timer_output_pin, .timer_output_pin_oe,
        .compare_a_flag, .compare_p_flag
    );
    stmctl_pin_model stmctl_pin_model_inst (
        .clk, .reset_n, .go, .n_pulses, .cap_level, .external_clock_pin,
        .capture_input_pin, .busy
    );
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // ======================================================================
    // bus tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic rd16(input logic [2:0] hi, output logic [15:0] d);
        rd(hi, d[15:8]);
        rd(hi - 3'h1, d[7:0]);
    endtask : rd16
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // ======================================================================
    // tests
    initial begin
        {reset_n, reg_wr, reg_rd, go, cap_level, reg_addr, reg_wdata, n_pulses} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rd(i[2:0], v8);
            chk("reset value", 16'h0000, 16'(v8));
        end
        wr(3'h0, 8'hF7);
        rd(3'h0, v8);
        chk("control 0", 16'h00F0, 16'(v8));
        wr(3'h1, 8'hA5);
        rd(3'h1, v8);
        chk("control 1", 16'h00A5, 16'(v8));
        wr(3'h3, 8'h55);
        rd(3'h3, v8);
        chk("count high", 16'h0000, 16'(v8));
        wr(3'h4, 8'h34);
        wr(3'h5, 8'h12);
        rd16(3'h5, v);
        chk("compare a", 16'h1234, v);
        $display("test registers done");
        wr(3'h0, 8'h10);
        wr(3'h1, 8'hC0);
        wr(3'h0, 8'h18);
        repeat (20) @(posedge clk);
        wr(3'h0, 8'h98);
        rd16(3'h3, v);
        repeat (10) @(posedge clk);
        rd16(3'h3, w);
        chk("paused count", v, w);
        chk("oe in counter mode", 16'h0000, 16'(timer_output_pin_oe));
        wr(3'h0, 8'h18);
        wr(3'h0, 8'h10);
        rd16(3'h3, w);
        chk("resumed count", v + 16'h0002, w);
        wr(3'h0, 8'h18);
        wr(3'h0, 8'h10);
        rd16(3'h3, w);
        chk("restart count", 16'h0001, 16'(w < 16'h0003));
        $display("test counting done");
        for (int p = 0; p < 2; p++) begin
            wr(3'h1, {5'b00100, p[0], 2'b01});
            wr(3'h4, 8'h10);
            wr(3'h5, 8'h00);
            wr(3'h7, 8'h07);
            wr(3'h0, 8'h18);
            #1 chk("pin start", 16'(p), 16'(timer_output_pin));
            chk("oe in compare mode", 16'h0001, 16'(timer_output_pin_oe));
            repeat (30) @(posedge clk);
            #1 chk("pin after match", 16'(p == 0), 16'(timer_output_pin));
            chk("flag a", 16'h0001, 16'(compare_a_flag));
            rd16(3'h3, v);
            chk("cleared on match a", 16'h0001, 16'(v <= 16'h0010));
            wr(3'h0, 8'h10);
        end
        wr(3'h7, 8'h07);
        #1 chk("flag a cleared", 16'h0000, 16'(compare_a_flag));
        $display("test compare done");
        wr(3'h1, 8'hC0);
        wr(3'h6, 8'h01);
        wr(3'h0, 8'h18);
        repeat (260) @(posedge clk);
        chk("flag p", 16'h0001, 16'(compare_p_flag));
        wr(3'h0, 8'h10);
        rd16(3'h3, v);
        chk("cleared on match p", 16'h0001, 16'(v < 16'h0100));
        for (int e = 0; e < 4; e++) begin
            wr(3'h0, 8'(32'h2808_7868 >> (8 * e)));
            go       <= 1'b1;
            n_pulses <= 8'h05;
            @(posedge clk);
            go <= 1'b0;
            repeat (60) @(posedge clk);
            rd16(3'h3, v);
            chk("selected clock count", 16'(8'(32'h030F_0505 >> (8 * e))), v);
            wr(3'h0, 8'h10);
        end
        $display("test external clock done");
        for (int c = 0; c < 4; c++) begin
            wr(3'h1, {2'b01, c[1:0], 4'h0});
            wr(3'h0, 8'h68);
            wr(3'h7, 8'h07);
            cap_level <= 1'b1;
            repeat (8) @(posedge clk);
            chk("capture rise", 16'(c == 0 || c == 2), 16'(compare_a_flag));
            wr(3'h7, 8'h07);
            cap_level <= 1'b0;
            repeat (8) @(posedge clk);
            chk("capture fall", 16'(c == 1 || c == 2), 16'(compare_a_flag));
            wr(3'h0, 8'h10);
        end
        $display("test capture done");
        summarize();
    end
    initial begin
        #500000;
        n_fail++;
        $display("unexpected watchdog: expected end seen hang");
        summarize();
    end
endmodule : stmctl_timer_tb_top
